// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wfpm_consts.vh"
// ==========
// Testbench
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, c;
    logic [3:0] pstrb;
    logic [7:0] b;
    wire [31:0] prdata;
    wire pready, pslverr, rx_valid, rx_last, rx_abort, irq;
    wire [7:0] rx_data;
    wire [3:1] wake_hit;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [63:0] mk [1:3] = '{{4{16'h8001}}, 64'h00FF, 64'h0003};
    logic [23:0] rows [18] = '{{8'h40, 16'hFFFF}, {8'h42, 16'hFFFF}, {8'h44, 16'hFFFF},
        {8'h46, 16'hFFFF}, {8'h48, 16'hFFFF}, {8'h4A, 16'hFFFF}, {8'h50, 16'hFFFF},
        {8'h52, 16'hFFFF}, {8'h54, 16'hFFFF}, {8'h56, 16'hFFFF}, {8'h58, 16'hFFFF},
        {8'h5A, 16'hFFFF}, {8'h60, 16'hFFFF}, {8'h62, 16'hFFFF}, {8'h64, 16'hFFFF},
        {8'h2A, 16'h000E}, {8'h4C, 16'h0000}, {8'h6D, 16'h000E}};
    wfpm_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_abort(rx_abort), .wake_hit(wake_hit), .irq(irq)
    );
    wfpm_rx_src src (
        .pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_abort(rx_abort)
    );
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    function automatic logic [31:0] crc_of(input logic [63:0] m);
        logic [31:0] v;
        v = `WFPM_CRC_INIT;
        for (int i = 1; i <= 64; i++) begin
            if (m[i-1]) begin
                v = v ^ {24'h0, src.fb(i)};
                repeat (8) v = v[0] ? (v >> 1) ^ `WFPM_CRC_POLY : v >> 1;
            end
        end
        return ~v;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frame(input int ab, input logic [7:0] x1, input logic [3:1] exp);
        src.send(70, ab, x1);
        #1 chk({29'h0, wake_hit}, {29'h0, exp}, "hit");
        @(posedge pclk);
        #1 chk({29'h0, wake_hit}, 32'h0, "hit width");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = {48'h0, 4'hF};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            b = rows[i][23:16];
            apb(1'b0, ba(b), 16'h0000);
            chk(rd, 32'h0, "reset value");
            apb(1'b1, ba(b), {b, ~b});
            apb(1'b0, ba(b), 16'h0000);
            chk(rd, {16'h0, {b, ~b} & rows[i][15:0]}, "readback");
        end
        apb(1'b0, 12'h102, 16'h0000);
        chk({31'h0, er}, 32'h1, "misaligned");
        apb(1'b0, ba(8'h70), 16'h0000);
        chk({er, rd[30:0]}, 32'h80000000, "unmapped");
        $display("register tests done");
        for (int s = 1; s <= 3; s++) begin
            b = 8'h30 + 8'(16 * s);
            c = crc_of(mk[s]);
            apb(1'b1, ba(b), c[15:0]);
            apb(1'b1, ba(b + 8'h02), c[31:16]);
            for (int w = 0; w < ((s == 3) ? 1 : 4); w++)
                apb(1'b1, ba(b + 8'h04 + 8'(2 * w)), mk[s][16*w +: 16]);
        end
        apb(1'b1, ba(8'h2A), 16'h000A);
        frame(0, 8'h00, 3'b101);
        c = crc_of(mk[1]);
        apb(1'b0, ba(8'h4C), 16'h0000);
        chk(rd, {16'h0, c[15:0]}, "last crc low");
        apb(1'b0, ba(8'h4D), 16'h0000);
        chk(rd, {16'h0, c[31:16]}, "last crc high");
        apb(1'b1, ba(8'h2A), 16'h000E);
        frame(70, 8'h00, 3'b000);
        frame(0, 8'h00, 3'b111);
        frame(0, 8'h40, 3'b000);
        $display("frame tests done");
        apb(1'b0, ba(8'h6C), 16'h0000);
        chk(rd, 32'hE, "status");
        apb(1'b1, ba(8'h6D), 16'h0000);
        #1 chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, ba(8'h6D), 16'h0002);
        #1 chk({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b1, ba(8'h6C), 16'h0002);
        #1 chk({31'h0, irq}, 32'h0, "irq cleared");
        apb(1'b0, ba(8'h6C), 16'h0000);
        chk(rd, 32'hC, "status after clear");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ba(8'h40), 16'h0000);
        chk({rd[30:0], irq}, 32'h0, "second reset");
        pstrb <= 4'h1;
        apb(1'b1, ba(8'h40), 16'hABCD);
        pstrb <= 4'hF;
        apb(1'b0, ba(8'h40), 16'h0000);
        chk(rd, 32'h000000CD, "byte lane");
        $display("irq and reset tests done");
        finish_test();
    end
endmodule // tb_top
`default_nettype wire

// File: bench/wfpm_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module wfpm_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire rx_valid,
    input wire rx_last,
    input wire rx_abort,
    input wire [3:1] wake_hit,
    input wire irq
);
    // Shadow copies, so hits can be tied to the programmed state
    reg [3:1] en_q;
    reg [3:1] mq_q;
    wire wr0 = psel && penable && pready && pwrite && pstrb[0];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 3'h0;
            mq_q <= 3'h0;
        end else begin
            if (wr0 && paddr == 12'h0A8) en_q <= pwdata[3:1];
            if (wr0 && paddr == 12'h1B4) mq_q <= pwdata[3:1];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_bad_setup; psel && !penable && paddr[1:0] != 2'b00; endsequence
    sequence s_access; psel && penable; endsequence
    property p_ready; 1'b1 |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_bad_align; s_bad_setup ##1 s_access |-> pslverr; endproperty
    a_bad_align: assert property (p_bad_align) else $error("no error on misaligned");
    property p_err_zero; s_access ##0 (!pwrite && pslverr) |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    property p_upper; s_access ##0 !pwrite |-> prdata[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_hit_last; wake_hit != 3'h0 |-> $past(rx_valid && rx_last && !rx_abort); endproperty
    a_hit_last: assert property (p_hit_last) else $error("hit without frame end");
    property p_abort; rx_abort |=> wake_hit == 3'h0; endproperty
    a_abort: assert property (p_abort) else $error("hit after abort");
    property p_enable; wake_hit != 3'h0 |-> (wake_hit & ~$past(en_q)) == 3'h0; endproperty
    a_enable: assert property (p_enable) else $error("hit on disabled slot");
    property p_irq; (wake_hit & mq_q) != 3'h0 |-> irq; endproperty
    a_irq: assert property (p_irq) else $error("unmasked hit without irq");
endmodule // wfpm_props
bind wfpm_top wfpm_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_last(rx_last), .rx_abort(rx_abort),
    .wake_hit(wake_hit), .irq(irq)
);
`default_nettype wire

// File: bench/wfpm_rx_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Receive byte source
module wfpm_rx_src (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_abort
);
    function automatic logic [7:0] fb(input int i);
        return i[7:0] * 8'h1D + 8'h07;
    endfunction
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        rx_abort = 1'b0;
    end
    // Gaps inside frames, idle data inverted so stale bytes never look valid
    // Byte i carries fb(i), byte 1 XORed with x1; a gap cycle goes before every seventh byte
    task automatic send(input int n, input int ab, input logic [7:0] x1);
        for (int i = 1; i <= n; i++) begin
            if (i % 7 == 0) begin
                @(posedge pclk);
                rx_valid <= 1'b0;
                rx_last <= 1'b0;
                rx_abort <= 1'b0;
                rx_data <= ~rx_data;
            end
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_data <= fb(i) ^ ((i == 1) ? x1 : 8'h00);
            rx_last <= (i == n);
            rx_abort <= (i == ab);
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_abort <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule // wfpm_rx_src
`default_nettype wire

// File: hw/wfpm_consts.vh
`ifndef WFPM_CONSTS_VH
`define WFPM_CONSTS_VH

// ============================================================
// Register indices; byte address is four times the index
// ============================================================
`define WFPM_IDX_CTRL 8'h2A
`define WFPM_IDX_S1_CRC_LO 8'h40
`define WFPM_IDX_S1_CRC_HI 8'h42
`define WFPM_IDX_S1_MASK0 8'h44
`define WFPM_IDX_S1_MASK1 8'h46
`define WFPM_IDX_S1_MASK2 8'h48
`define WFPM_IDX_S1_MASK3 8'h4A
`define WFPM_IDX_S2_CRC_LO 8'h50
`define WFPM_IDX_S2_CRC_HI 8'h52
`define WFPM_IDX_S2_MASK0 8'h54
`define WFPM_IDX_S2_MASK1 8'h56
`define WFPM_IDX_S2_MASK2 8'h58
`define WFPM_IDX_S2_MASK3 8'h5A
`define WFPM_IDX_S3_CRC_LO 8'h60
`define WFPM_IDX_S3_CRC_HI 8'h62
`define WFPM_IDX_S3_MASK0 8'h64
`define WFPM_IDX_STATUS 8'h6C
`define WFPM_IDX_IRQ_MASK 8'h6D
`define WFPM_IDX_S1_LAST_LO 8'h4C
`define WFPM_IDX_S1_LAST_HI 8'h4D
`define WFPM_IDX_S2_LAST_LO 8'h5C
`define WFPM_IDX_S2_LAST_HI 8'h5D
`define WFPM_IDX_S3_LAST_LO 8'h6E
`define WFPM_IDX_S3_LAST_HI 8'h6F

// ============================================================
// Fields and reset values
// ============================================================
`define WFPM_EN_LSB 1
`define WFPM_EN_MSB 3
`define WFPM_REG_RESET 16'h0000
`define WFPM_CTRL_RESET 3'h0
`define WFPM_CRC_POLY 32'hEDB88320
`define WFPM_CRC_INIT 32'hFFFFFFFF
`define WFPM_MASK_BYTES 7'h40

// ============================================================
// Internal decode codes
// ============================================================
`define WFPM_CODE_CTRL 5'h10
`define WFPM_CODE_STATUS 5'h11
`define WFPM_CODE_IRQ_MASK 5'h12
`define WFPM_CODE_LAST 5'h13
`define WFPM_CODE_NONE 5'h1F

`endif

// File: hw/wfpm_top.v
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "wfpm_consts.vh"

// Overview of operation
// - Each slot runs an Ethernet CRC-32 over received bytes whose mask bit is set.
// - First CRC register bits 15-0 hold the expected CRC's lower half.
// - Second CRC register bits 15-0 hold the expected CRC's upper half.
// - First mask word: bit 0 picks byte 1, bit 15 picks byte 16.
// - Second mask word: bit 0 picks byte 17, bit 15 picks byte 32.
// - Third mask word: bit 0 picks byte 33, bit 15 picks byte 48.
// - Fourth mask word covers bytes 49 to 64; later bytes never count.
// - Slot 1 and 2 CRC and mask registers are read-write, reset zero.
// - A slot detects only while its enable bit 1, 2 or 3 is set.
module wfpm_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_last,
    input wire rx_abort,
    output reg [3:1] wake_hit,
    output wire irq
);

    // ========================================================
    // Functions
    // ========================================================
    // One byte of the reflected CRC-32, LSB of the byte first
    function [31:0] crc_byte;
        input [31:0] c;
        input [7:0] d;
        integer i;
        reg [31:0] r;
        begin
            r = c;
            for (i = 0; i < 8; i = i + 1) begin
                if (r[0] ^ d[i]) begin
                    r = (r >> 1) ^ `WFPM_CRC_POLY;
                end else begin
                    r = r >> 1;
                end
            end
            crc_byte = r;
        end
    endfunction

    // Address to storage index (0..14) or decode code
    function [4:0] decode;
        input [11:0] a;
        begin
            if (a[1:0] != 2'b00 || a[11:10] != 2'b00) begin
                decode = `WFPM_CODE_NONE;
            end else begin
                case (a[9:2])
                    `WFPM_IDX_S1_CRC_LO: decode = 5'd0;
                    `WFPM_IDX_S1_CRC_HI: decode = 5'd1;
                    `WFPM_IDX_S1_MASK0: decode = 5'd2;
                    `WFPM_IDX_S1_MASK1: decode = 5'd3;
                    `WFPM_IDX_S1_MASK2: decode = 5'd4;
                    `WFPM_IDX_S1_MASK3: decode = 5'd5;
                    `WFPM_IDX_S2_CRC_LO: decode = 5'd6;
                    `WFPM_IDX_S2_CRC_HI: decode = 5'd7;
                    `WFPM_IDX_S2_MASK0: decode = 5'd8;
                    `WFPM_IDX_S2_MASK1: decode = 5'd9;
                    `WFPM_IDX_S2_MASK2: decode = 5'd10;
                    `WFPM_IDX_S2_MASK3: decode = 5'd11;
                    `WFPM_IDX_S3_CRC_LO: decode = 5'd12;
                    `WFPM_IDX_S3_CRC_HI: decode = 5'd13;
                    `WFPM_IDX_S3_MASK0: decode = 5'd14;
                    `WFPM_IDX_CTRL: decode = `WFPM_CODE_CTRL;
                    `WFPM_IDX_STATUS: decode = `WFPM_CODE_STATUS;
                    `WFPM_IDX_IRQ_MASK: decode = `WFPM_CODE_IRQ_MASK;
                    `WFPM_IDX_S1_LAST_LO: decode = 5'h13;
                    `WFPM_IDX_S1_LAST_HI: decode = 5'h14;
                    `WFPM_IDX_S2_LAST_LO: decode = 5'h15;
                    `WFPM_IDX_S2_LAST_HI: decode = 5'h16;
                    `WFPM_IDX_S3_LAST_LO: decode = 5'h17;
                    `WFPM_IDX_S3_LAST_HI: decode = 5'h18;
                    default: decode = `WFPM_CODE_NONE;
                endcase
            end
        end
    endfunction

    // Byte-lane merge for the 16-bit registers
    function [15:0] merge;
        input [15:0] old;
        input [31:0] wd;
        input [3:0] st;
        begin
            merge[7:0] = st[0] ? wd[7:0] : old[7:0];
            merge[15:8] = st[1] ? wd[15:8] : old[15:8];
        end
    endfunction

    // ========================================================
    // APB slave
    // ========================================================
    // Read data is captured in the setup cycle so the access
    // phase completes at once with flop-driven data
    wire [4:0] code_w;
    wire setup_w;
    wire wr_w;
    reg [15:0] regs_q [0:14];
    reg [3:1] en_q;
    reg [3:1] status_q;
    reg [3:1] irq_mask_q;
    wire [95:0] last_all;
    wire [3:1] hit_w;
    reg [15:0] rd_w;
    integer k;

    assign code_w = decode(paddr);
    assign setup_w = psel & ~penable;
    assign wr_w = psel & penable & pwrite & (code_w != `WFPM_CODE_NONE);
    assign pready = 1'b1;

    always @* begin
        rd_w = 16'h0000;
        if (code_w < 5'd15) begin
            rd_w = regs_q[code_w[3:0]];
        end else begin
            case (code_w)
                `WFPM_CODE_CTRL: rd_w = {12'h000, en_q, 1'b0};
                `WFPM_CODE_STATUS: rd_w = {12'h000, status_q, 1'b0};
                `WFPM_CODE_IRQ_MASK: rd_w = {12'h000, irq_mask_q, 1'b0};
                5'h13: rd_w = last_all[15:0];
                5'h14: rd_w = last_all[31:16];
                5'h15: rd_w = last_all[47:32];
                5'h16: rd_w = last_all[63:48];
                5'h17: rd_w = last_all[79:64];
                5'h18: rd_w = last_all[95:80];
                default: rd_w = 16'h0000;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_w) begin
            prdata <= {16'h0000, rd_w};
            pslverr <= (code_w == `WFPM_CODE_NONE);
        end
    end

    // ========================================================
    // Pattern registers
    // ========================================================
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (k = 0; k < 15; k = k + 1) begin
                regs_q[k] <= `WFPM_REG_RESET;
            end
        end else if (wr_w && code_w < 5'd15) begin
            regs_q[code_w[3:0]] <= merge(regs_q[code_w[3:0]], pwdata, pstrb);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= `WFPM_CTRL_RESET;
            irq_mask_q <= 3'h0;
        end else if (wr_w && pstrb[0]) begin
            if (code_w == `WFPM_CODE_CTRL) begin
                en_q <= pwdata[`WFPM_EN_MSB:`WFPM_EN_LSB];
            end
            if (code_w == `WFPM_CODE_IRQ_MASK) begin
                irq_mask_q <= pwdata[`WFPM_EN_MSB:`WFPM_EN_LSB];
            end
        end
    end

    // ========================================================
    // Status and interrupt
    // ========================================================
    // A detection in the clearing cycle survives the clear
    wire [3:1] clr_w;
    assign clr_w = (wr_w && pstrb[0] && code_w == `WFPM_CODE_STATUS) ?
        pwdata[`WFPM_EN_MSB:`WFPM_EN_LSB] : 3'h0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 3'h0;
            wake_hit <= 3'h0;
        end else begin
            status_q <= (status_q & ~clr_w) | hit_w;
            wake_hit <= hit_w;
        end
    end

    assign irq = |(status_q & irq_mask_q);

    // ========================================================
    // Receive byte position
    // ========================================================
    // Saturates at 64: bytes past the mask window are never picked
    reg [6:0] pos_q;
    wire end_w;
    wire take_w;
    assign take_w = rx_valid & ~rx_abort;
    assign end_w = take_w & rx_last;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 7'h00;
        end else if (rx_abort || end_w) begin
            pos_q <= 7'h00;
        end else if (take_w && pos_q != `WFPM_MASK_BYTES) begin
            pos_q <= pos_q + 7'h01;
        end
    end

    // ========================================================
    // Per-slot CRC engines
    // ========================================================
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_slot
            wire [63:0] mask_w;
            wire [31:0] expect_w;
            wire sel_w;
            wire [31:0] crc_d;
            wire [31:0] fin_w;
            reg [31:0] crc_q;
            reg any_q;
            reg [31:0] last_q;

            // Bit n of the 64-bit mask picks frame byte n+1
            if (g == 2) begin : g_short
                assign mask_w = {48'h000000000000, regs_q[6*g+2]};
            end else begin : g_full
                assign mask_w = {regs_q[6*g+5],
                                 regs_q[6*g+4],
                                 regs_q[6*g+3],
                                 regs_q[6*g+2]};
            end

            assign expect_w = {regs_q[6*g+1],
                               regs_q[6*g]};

            assign sel_w = take_w & en_q[g+1] & ~pos_q[6] & mask_w[pos_q[5:0]];
            assign crc_d = sel_w ? crc_byte(crc_q, rx_data) : crc_q;
            assign fin_w = ~crc_d;

            // An empty mask never matches, else reset state would wake
            assign hit_w[g+1] = end_w & en_q[g+1] & (any_q | sel_w) &
                (fin_w == expect_w);

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    crc_q <= `WFPM_CRC_INIT;
                    any_q <= 1'b0;
                    last_q <= 32'h00000000;
                end else if (rx_abort) begin
                    crc_q <= `WFPM_CRC_INIT;
                    any_q <= 1'b0;
                end else if (end_w) begin
                    crc_q <= `WFPM_CRC_INIT;
                    any_q <= 1'b0;
                    last_q <= fin_w;
                end else begin
                    crc_q <= crc_d;
                    any_q <= any_q | sel_w;
                end
            end

            assign last_all[32*g+31:32*g] = last_q;
        end
    endgenerate

endmodule // wfpm_top

`default_nettype wire
